/* core/irc_top.v */
// infrared carrier generator and transmitter output stage
// assumes an AHB-Lite master on the same clock and a modulator on the
// same clock that supplies its gate level and a set-switch pulse
`timescale 1ns/10ps
`include "irc_map.vh"
module irc_top #(
	parameter CNT_W = 6
) (
	input  wire        CLOCK_I,
	input  wire        RESET_I,

	// ahb-lite slave port
	input  wire        HSEL_I,
	input  wire [31:0] HADDR_I,
	input  wire [1:0]  HTRANS_I,
	input  wire        HWRITE_I,
	input  wire [2:0]  HSIZE_I,
	input  wire [31:0] HWDATA_I,
	input  wire        HREADY_I,
	output reg  [31:0] HRDATA_O,
	output reg         HREADYOUT_O,
	output reg         HRESP_O,

	// modulator interface
	input  wire        MOD_GATE_I,
	input  wire        MOD_SWITCH_I,
	output reg         CARRIER_O,

	// infrared output pin
	output reg         INFRARED_OUTPUT_PIN_O
);

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------

	// primary and secondary count sets
	reg [CNT_W-1:0] pri_high_q;
	reg [CNT_W-1:0] pri_low_q;
	reg [CNT_W-1:0] sec_high_q;
	reg [CNT_W-1:0] sec_low_q;

	// modulator control and status bits
	reg             module_enable_q;
	reg             fsk_mode_q;
	reg             baseband_q;
	reg             halve_clock_q;

	// active count set and clock divider
	reg             sec_sel_q;
	reg             div_q;

	// ahb data-phase bookkeeping
	reg             wr_pend_q;
	reg  [7:0]      wr_addr_q;

	// ------------------------------------------------------------
	// wires
	// ------------------------------------------------------------

	wire            addr_take;
	wire            addr_mapped;
	wire [7:0]      addr_lo;
	wire            wr_now;
	wire            wr_pri_high;
	wire            wr_pri_low;
	wire            wr_sec_high;
	wire            wr_sec_low;
	wire            wr_ctrl;
	wire            gen_run;
	wire            gen_step;
	wire [CNT_W-1:0] act_high;
	wire [CNT_W-1:0] act_low;
	wire            raw_carrier;
	wire            carrier_to_mod;
	wire            mod_out;
	wire            latch_val;
	reg  [31:0]     rd_d;

	// ------------------------------------------------------------
	// ahb-lite address phase
	// ------------------------------------------------------------

	// a transfer is taken on a nonseq or seq cycle with hready high
	assign addr_take   = HSEL_I & HREADY_I & HTRANS_I[1];
	assign addr_lo     = HADDR_I[7:0];

	// only the five words at the bottom of the window are mapped
	assign addr_mapped = (HADDR_I[31:8] == 24'h000000) && (addr_lo[1:0] == 2'h0) &&
		(addr_lo <= `IRC_CTRL_OFS);

	// remember a write for its data phase
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_take & HWRITE_I & addr_mapped;
			wr_addr_q <= addr_lo;
		end
	end

	// ------------------------------------------------------------
	// ahb-lite data phase decode
	// ------------------------------------------------------------

	// write strobes, one cycle each, in the data phase
	assign wr_now      = wr_pend_q;
	assign wr_pri_high = wr_now && (wr_addr_q == `IRC_PRI_HIGH_OFS);
	assign wr_pri_low  = wr_now && (wr_addr_q == `IRC_PRI_LOW_OFS);
	assign wr_sec_high = wr_now && (wr_addr_q == `IRC_SEC_HIGH_OFS);
	assign wr_sec_low  = wr_now && (wr_addr_q == `IRC_SEC_LOW_OFS);
	assign wr_ctrl     = wr_now && (wr_addr_q == `IRC_CTRL_OFS);

	// count registers, loaded from the low bits of the write data
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			pri_high_q <= `IRC_CNT_RST;
			pri_low_q  <= `IRC_CNT_RST;
			sec_high_q <= `IRC_CNT_RST;
			sec_low_q  <= `IRC_CNT_RST;
		end else begin
			if (wr_pri_high) begin
				pri_high_q <= HWDATA_I[`IRC_CNT_MSB:0];
			end
			if (wr_pri_low) begin
				pri_low_q <= HWDATA_I[`IRC_CNT_MSB:0];
			end
			if (wr_sec_high) begin
				sec_high_q <= HWDATA_I[`IRC_CNT_MSB:0];
			end
			if (wr_sec_low) begin
				sec_low_q <= HWDATA_I[`IRC_CNT_MSB:0];
			end
		end
	end

	// control bits
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			module_enable_q <= `IRC_CTRL_RST;
			fsk_mode_q      <= `IRC_CTRL_RST;
			baseband_q      <= `IRC_CTRL_RST;
			halve_clock_q   <= `IRC_CTRL_RST;
		end else if (wr_ctrl) begin
			module_enable_q <= HWDATA_I[`IRC_EN_BIT];
			fsk_mode_q      <= HWDATA_I[`IRC_FSK_BIT];
			baseband_q      <= HWDATA_I[`IRC_BASEBAND_SELECT_BIT];
			halve_clock_q   <= HWDATA_I[`IRC_HALVE_BIT];
		end
	end

	// ------------------------------------------------------------
	// read data, gathered in the address phase
	// ------------------------------------------------------------

	// unmapped words and reserved bits read as zero
	always @* begin
		rd_d = 32'h00000000;
		case (addr_lo)
			`IRC_PRI_HIGH_OFS: begin
				rd_d[`IRC_CNT_MSB:0] = pri_high_q;
				rd_d[`IRC_LATCH_BIT] = latch_val;
			end
			`IRC_PRI_LOW_OFS: begin
				rd_d[`IRC_CNT_MSB:0] = pri_low_q;
				rd_d[`IRC_LATCH_BIT] = latch_val;
			end
			`IRC_SEC_HIGH_OFS: begin
				rd_d[`IRC_CNT_MSB:0] = sec_high_q;
			end
			`IRC_SEC_LOW_OFS: begin
				rd_d[`IRC_CNT_MSB:0] = sec_low_q;
			end
			`IRC_CTRL_OFS: begin
				rd_d[`IRC_EN_BIT]    = module_enable_q;
				rd_d[`IRC_FSK_BIT]   = fsk_mode_q;
				rd_d[`IRC_BASEBAND_SELECT_BIT]  = baseband_q;
				rd_d[`IRC_SEL_BIT]   = sec_sel_q;
				rd_d[`IRC_CARR_BIT]  = raw_carrier;
				rd_d[`IRC_HALVE_BIT] = halve_clock_q;
			end
			default: begin
				rd_d = 32'h00000000;
			end
		endcase
		if (!addr_mapped) begin
			rd_d = 32'h00000000;
		end
	end

	// registered read data; zero wait states, always okay
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			HRDATA_O    <= 32'h00000000;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end else begin
			HRDATA_O    <= (addr_take && !HWRITE_I) ? rd_d : 32'h00000000;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// carrier generator clocking
	// ------------------------------------------------------------

	// generator clocks only while enabled and not in baseband
	assign gen_run = module_enable_q & ~baseband_q;

	// divide-by-two prescaler; otherwise one step per clock
	always @(posedge CLOCK_I) begin
		if (RESET_I || !gen_run) begin
			div_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
		end
	end

	assign gen_step = halve_clock_q ? div_q : 1'b1;

	// ------------------------------------------------------------
	// count set selection
	// ------------------------------------------------------------

	// time mode holds the primary set; fsk toggles on each switch
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			sec_sel_q <= 1'b0;
		end else if (!fsk_mode_q || !module_enable_q) begin
			sec_sel_q <= 1'b0;
		end else if (MOD_SWITCH_I) begin
			sec_sel_q <= ~sec_sel_q;
		end
	end

	assign act_high = sec_sel_q ? sec_high_q : pri_high_q;
	assign act_low  = sec_sel_q ? sec_low_q  : pri_low_q;

	// ------------------------------------------------------------
	// time counter
	// ------------------------------------------------------------

	// high for the high count, low for the low count
	irc_cg_counter #(
		.WIDTH      (CNT_W)
	) u_counter (
		.clk_i      (CLOCK_I),
		.rst_i      (RESET_I),
		.run_i      (gen_run),
		.step_i     (gen_step),
		.high_cnt_i (act_high),
		.low_cnt_i  (act_low),
		.carrier_q  (raw_carrier),
		.in_low_q   ()
	);

	// ------------------------------------------------------------
	// modulator path
	// ------------------------------------------------------------

	// baseband forces the carrier seen by the modulator high
	assign carrier_to_mod = baseband_q | raw_carrier;

	// time and baseband gate the carrier; fsk routes it straight
	assign mod_out = fsk_mode_q ? carrier_to_mod : (carrier_to_mod & MOD_GATE_I);

	// carrier as handed to the modulator
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			CARRIER_O <= 1'b1;
		end else begin
			CARRIER_O <= carrier_to_mod;
		end
	end

	// ------------------------------------------------------------
	// output override latch
	// ------------------------------------------------------------

	// primary high-time writes act at once, low-time writes a clock later
	irc_out_latch u_latch (
		.clk_i     (CLOCK_I),
		.rst_i     (RESET_I),
		.wr_fall_i (wr_pri_high),
		.wr_rise_i (wr_pri_low),
		.d_fall_i  (HWDATA_I[`IRC_LATCH_BIT]),
		.d_rise_i  (HWDATA_I[`IRC_LATCH_BIT]),
		.latch_q   (latch_val)
	);

	// ------------------------------------------------------------
	// transmitter output stage
	// ------------------------------------------------------------

	// modulator drives the pin when enabled, else the latch does
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			INFRARED_OUTPUT_PIN_O <= `IRC_LATCH_RST;
		end else if (module_enable_q) begin
			INFRARED_OUTPUT_PIN_O <= mod_out;
		end else begin
			INFRARED_OUTPUT_PIN_O <= latch_val;
		end
	end

endmodule // irc_top

/* core/irc_map.vh */
// register map, field positions and reset values of the infrared carrier generator
// assumes a 32-bit AHB-Lite slave port with one register per aligned word
`ifndef IRC_MAP_VH
`define IRC_MAP_VH

// byte offsets of the registers
`define IRC_PRI_HIGH_OFS   8'h00
`define IRC_PRI_LOW_OFS    8'h04
`define IRC_SEC_HIGH_OFS   8'h08
`define IRC_SEC_LOW_OFS    8'h0c
`define IRC_CTRL_OFS       8'h10

// field positions
`define IRC_LATCH_BIT      7
`define IRC_CNT_MSB        5
`define IRC_EN_BIT         0
`define IRC_FSK_BIT        1
`define IRC_BASEBAND_SELECT_BIT       3
`define IRC_SEL_BIT        4
`define IRC_CARR_BIT       5
`define IRC_HALVE_BIT      6

// reset values
`define IRC_CNT_RST        6'h00
`define IRC_CTRL_RST       1'b0
`define IRC_LATCH_RST      1'b0

// one count is one clock of 40 ns at 25 MHz
`define IRC_CLK_NS         40
`define IRC_COUNT_CYCLES   1

`endif

/* core/irc_cg_counter.v */
// six-bit high/low time counter that builds the raw carrier
// assumes step pulses come from the parent on the same clock
`timescale 1ns/10ps
module irc_cg_counter #(
	parameter WIDTH = 6
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             run_i,
	input  wire             step_i,
	input  wire [WIDTH-1:0] high_cnt_i,
	input  wire [WIDTH-1:0] low_cnt_i,
	output reg              carrier_q,
	output reg              in_low_q
);
	reg  [WIDTH-1:0] cnt_q;
	wire [WIDTH-1:0] cnt_inc;
	wire [WIDTH-1:0] active_cnt;
	wire             hit;

	// compare the incremented value with the phase's own count
	assign cnt_inc    = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
	assign active_cnt = in_low_q ? low_cnt_i : high_cnt_i;
	assign hit        = (cnt_inc == active_cnt);

	// count, clear on match and swap phase
	always @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q     <= {WIDTH{1'b0}};
			in_low_q  <= 1'b0;
			carrier_q <= 1'b1;
		end else if (step_i) begin
			if (hit) begin
				cnt_q     <= {WIDTH{1'b0}};
				in_low_q  <= ~in_low_q;
				carrier_q <= in_low_q;
			end else begin
				cnt_q <= cnt_inc;
			end
		end
	end
endmodule // irc_cg_counter

/* core/irc_out_latch.v */
// cpu-written output override latch with two write timings
// assumes write pulses are single-cycle strobes on the oscillator clock
`timescale 1ns/10ps
module irc_out_latch (
	input  wire clk_i,
	input  wire rst_i,
	input  wire wr_fall_i,
	input  wire wr_rise_i,
	input  wire d_fall_i,
	input  wire d_rise_i,
	output reg  latch_q
);
	reg pend_q;
	reg pend_val_q;

	// rising-edge writes wait one oscillator period
	always @(posedge clk_i) begin
		if (rst_i) begin
			pend_q     <= 1'b0;
			pend_val_q <= 1'b0;
		end else begin
			pend_q     <= wr_rise_i;
			pend_val_q <= d_rise_i;
		end
	end

	// falling-edge write lands at once; it wins over a pending one
	always @(posedge clk_i) begin
		if (rst_i) begin
			latch_q <= 1'b0;
		end else if (wr_fall_i) begin
			latch_q <= d_fall_i;
		end else if (pend_q) begin
			latch_q <= pend_val_q;
		end
	end
endmodule // irc_out_latch

/* sim/irc_top_assertions.sv */
// port checker for the infrared carrier generator top
// assumes one clock domain and a single bus master
`timescale 1ns/10ps
module irc_chk #(
	parameter CNT_W = 6
) (
	input wire        CLOCK_I,
	input wire        RESET_I,
	input wire        HSEL_I,
	input wire [31:0] HADDR_I,
	input wire [1:0]  HTRANS_I,
	input wire        HWRITE_I,
	input wire [2:0]  HSIZE_I,
	input wire [31:0] HWDATA_I,
	input wire        HREADY_I,
	input wire [31:0] HRDATA_O,
	input wire        HREADYOUT_O,
	input wire        HRESP_O,
	input wire        MOD_GATE_I,
	input wire        MOD_SWITCH_I,
	input wire        CARRIER_O,
	input wire        INFRARED_OUTPUT_PIN_O
);
	logic             wr_q, rd_q, lat_q, en_q, fsk_q, baseband_select_q, halve_q, last_q;
	logic [7:0]       ra_q, run_q, age_q;
	logic [CNT_W-1:0] ph_q, pl_q;
	wire              take = HSEL_I && HREADY_I && HTRANS_I[1];
	wire              quiet = en_q && !baseband_select_q && !fsk_q && age_q == 8'hff;
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	// shadow of written state, carrier run length, cycles since last change
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			{wr_q, rd_q, lat_q, en_q, fsk_q, baseband_select_q, halve_q, ph_q, pl_q} <= '0;
			{ra_q, run_q, age_q, last_q} <= '0;
		end else begin
			wr_q   <= take && HWRITE_I;
			rd_q   <= take && !HWRITE_I;
			ra_q   <= HADDR_I[7:0];
			last_q <= CARRIER_O;
			run_q  <= (CARRIER_O != last_q) ? 8'h01 : run_q + 8'h01;
			age_q  <= (wr_q || MOD_SWITCH_I) ? 8'h00 : age_q + {7'h0, age_q != 8'hff};
			if (wr_q && ra_q == 8'h00)
				{lat_q, ph_q} <= {HWDATA_I[7], HWDATA_I[CNT_W-1:0]};
			if (wr_q && ra_q == 8'h04)
				{lat_q, pl_q} <= {HWDATA_I[7], HWDATA_I[CNT_W-1:0]};
			if (wr_q && ra_q == 8'h10)
				{halve_q, baseband_select_q, fsk_q, en_q} <= {HWDATA_I[6], HWDATA_I[3], HWDATA_I[1:0]};
		end
	end
	property p_rd_idle; !rd_q |-> HRDATA_O == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_rd_low; rd_q && ra_q == 8'h04 |-> HRDATA_O[CNT_W-1:0] == $past(pl_q); endproperty
	a_rd_low: assert property (p_rd_low) else $error("low count readback");
	property p_idle_high; (!en_q || baseband_select_q)[*4] |-> CARRIER_O; endproperty
	a_idle_high: assert property (p_idle_high) else $error("carrier not held");
	property p_latch_pin; (!en_q && $stable(lat_q))[*4] |-> INFRARED_OUTPUT_PIN_O == lat_q; endproperty
	a_latch_pin: assert property (p_latch_pin) else $error("pin not latch");
	property p_gate_low; (en_q && !fsk_q && !MOD_GATE_I)[*2] |=> !INFRARED_OUTPUT_PIN_O; endproperty
	a_gate_low: assert property (p_gate_low) else $error("gate ignored");
	property p_baseband_select; (en_q && baseband_select_q && MOD_GATE_I)[*3] |=> INFRARED_OUTPUT_PIN_O; endproperty
	a_baseband_select: assert property (p_baseband_select) else $error("baseband mark lost");
	property p_high_run; $fell(CARRIER_O) && quiet |-> run_q == (8'(ph_q) << halve_q); endproperty
	a_high_run: assert property (p_high_run) else $error("high time wrong");
	property p_low_run; $rose(CARRIER_O) && quiet |-> run_q == (8'(pl_q) << halve_q); endproperty
	a_low_run: assert property (p_low_run) else $error("low time wrong");
	property p_reset; $fell(RESET_I) |-> !INFRARED_OUTPUT_PIN_O && CARRIER_O; endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	property p_bus_ok; HREADYOUT_O && !HRESP_O; endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready okay");
	property p_start_high; $rose(en_q) |-> CARRIER_O[*2]; endproperty
	a_start_high: assert property (p_start_high) else $error("carrier low at start");
	c_run: cover property ($fell(CARRIER_O) && quiet);
	c_baseband_select: cover property ((en_q && baseband_select_q && MOD_GATE_I)[*3]);
	c_rd: cover property (rd_q && ra_q == 8'h04);
endmodule // irc_chk

bind irc_top irc_chk #(.CNT_W(CNT_W)) u_chk (
	.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
	.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
	.HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
	.MOD_GATE_I(MOD_GATE_I), .MOD_SWITCH_I(MOD_SWITCH_I), .CARRIER_O(CARRIER_O),
	.INFRARED_OUTPUT_PIN_O(INFRARED_OUTPUT_PIN_O)
);

/* sim/irc_emitter.sv */
// emitter driver model: measures marks and spaces on the infrared pin
// assumes the pin is a registered level on the bench clock
`timescale 1ns/10ps
module irc_emitter (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        pin_i,
	output logic [7:0] hi_len_o,
	output logic [7:0] lo_len_o
);
	logic       last_q;
	logic [7:0] run_q;
	// length in clocks of the last finished mark and space
	always @(posedge clk_i) begin
		if (rst_i) begin
			{last_q, run_q, hi_len_o, lo_len_o} <= '0;
		end else begin
			last_q <= pin_i;
			run_q  <= (pin_i != last_q) ? 8'h01 : run_q + 8'h01;
			if (pin_i != last_q && last_q)
				hi_len_o <= run_q;
			if (pin_i != last_q && !last_q)
				lo_len_o <= run_q;
		end
	end
endmodule // irc_emitter

/* sim/tb_ir_carrier_generator.sv */
// self-checking bench for the infrared carrier generator
// assumes a zero-wait bus slave and the emitter model on the pin
`timescale 1ns/10ps
module tb_ir_carrier_generator;
	logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, gate = 1'b0, sw = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [7:0]  mode [4] = '{8'h01, 8'h41, 8'h03, 8'h03};
	logic [7:0]  hi_x [4] = '{8'h02, 8'h04, 8'h02, 8'h01};
	logic [7:0]  lo_x [4] = '{8'h03, 8'h06, 8'h03, 8'h04};
	wire  [31:0] hrdata;
	wire         hready, carrier, pin;
	wire  [7:0]  hi_len, lo_len;
	int          error_cnt = 0, checked = 0;

	// 25 MHz clock
	always #20 clk = ~clk;

	irc_top #(.CNT_W(6)) dut (
		.CLOCK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
		.HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .MOD_GATE_I(gate),
		.MOD_SWITCH_I(sw), .CARRIER_O(carrier), .INFRARED_OUTPUT_PIN_O(pin)
	);
	irc_emitter emit (.clk_i(clk), .rst_i(rst), .pin_i(pin), .hi_len_o(hi_len), .lo_len_o(lo_len));

	// one single word transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// pin level after n falling edges, where it has settled
	task automatic pin_at(input int n, input logic e);
		repeat (n) @(negedge clk);
		chk(32'(pin), 32'(e));
	endtask

	task automatic pulse;
		sw <= 1'b1;
		@(posedge clk);
		sw <= 1'b0;
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// the tests take about 1300 clocks
	initial begin
		repeat (6000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		xfer(1'b0, 32'h10, 32'h0);
		chk(rd & 32'hffffffdf, 32'h0);
		chk(32'(pin), 32'h0);
		xfer(1'b1, 32'h20, 32'hff);
		xfer(1'b0, 32'h20, 32'h0);
		chk(rd, 32'h0); // unmapped place stays empty
		xfer(1'b1, 32'h0, 32'h82);
		pin_at(1, 1'b0);
		pin_at(1, 1'b1);
		xfer(1'b1, 32'h4, 32'h03);
		pin_at(2, 1'b1);
		pin_at(1, 1'b0);
		xfer(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h02);
		xfer(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h03);
		xfer(1'b1, 32'h8, 32'h01);
		xfer(1'b1, 32'hc, 32'h04);
		gate <= 1'b1;
		// time, halved, fsk primary, fsk secondary after a switch
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, 32'h10, 32'(mode[i]));
			if (i == 3)
				pulse();
			repeat (300) @(posedge clk);
			chk(32'(hi_len), 32'(hi_x[i]));
			chk(32'(lo_len), 32'(lo_x[i]));
		end
		xfer(1'b0, 32'h10, 32'h0);
		chk(rd & 32'h10, 32'h10);
		pulse();
		xfer(1'b0, 32'h10, 32'h0);
		chk(rd & 32'h10, 32'h0);
		xfer(1'b1, 32'h10, 32'h01);
		gate <= 1'b0;
		xfer(1'b1, 32'h0, 32'h82); // latch set while enabled
		pin_at(4, 1'b0);
		xfer(1'b1, 32'h10, 32'h09);
		gate <= 1'b1;
		pin_at(4, 1'b1);
		chk(32'(carrier), 32'h1);
		@(posedge clk) gate <= 1'b0;
		pin_at(3, 1'b0);
		xfer(1'b1, 32'h10, 32'h00);
		pin_at(4, 1'b1); // latch shows again once disabled
		chk(32'(carrier), 32'h1);
		conclude();
	end
endmodule // tb_ir_carrier_generator
